// ===== hdl/sdc_regs.v
// control and diagnostic registers of the inertial sensor, reached over the serial port
// How it works
// - sample period setting zero switches sampling to the external input clock.
// - after reset data-ready drives the first line, active high.
// - each data-ready pulse lasts between 100 and 200 microseconds.
// - misc bit 2 enables, bit 1 sets polarity, bit 0 selects line.
// - misc bit 11 starts checksum test, cleared by hardware on completion.
// - misc bit 10 runs self-test, results posted within 35 ms, then cleared.
// - misc bits 9 and 8 apply negative and positive stimulus while set.
// - misc bit 7 enables rate compensation for linear acceleration.
// - misc bit 6 enables accelerometer point-of-percussion alignment.
// - converter value is staged; only the latch command moves it out.
// - converter code sits in bits 11:0, offset binary, 0.8059 mV per step.
// - sixteen-bit counter increments on every nonvolatile write; readable.
// - reading diagnostic flags clears all but the two supply flags.
// - a persisting alarm, over-range or memory-update error sets its flag again on the next sample.
// - supply flags follow the supply and clear without a read.
// - bits 15..13 flag accelerometer and bit 10 gyro self-test failure.
// - bits 9 and 8 show alarm two and alarm one activity.
// - bit 4 flags sensor over-range.
// - bit 2 flags failed memory update, bit 5 self-test diagnostic error.
// - bit 3 sets when a frame ends off a multiple of 16 clocks.
// - global command bit 2 is the latch strobe and stores nothing.
`include "sdc_consts.vh"
`default_nettype none
module sdc_regs #(
    parameter integer TB_SHORT_CYC = `SDC_TB_SHORT_NS * `SDC_CLK_MHZ / `SDC_NS_PER_US,
    parameter integer TB_LONG_CYC  = `SDC_TB_LONG_NS * `SDC_CLK_MHZ / `SDC_NS_PER_US,
    parameter integer SELFTEST_CYC = `SDC_SELFTEST_MS * `SDC_US_PER_MS * `SDC_CLK_MHZ,
    parameter integer CHKSUM_CYC   = `SDC_CHKSUM_MS * `SDC_US_PER_MS * `SDC_CLK_MHZ
) (
    // clock and reset
    input  wire                  clk,
    input  wire                  sys_rst,
    // serial port pins
    input  wire                  spi_cs_n,
    input  wire                  spi_sclk,
    input  wire                  spi_mosi,
    output reg                   spi_miso,
    output wire                  spi_miso_oe_n,
    // external sample clock pin
    input  wire                  ext_sample_clk,
    // general-purpose lines used for data-ready
    output reg                   io_line_first_out,
    output reg                   io_line_first_oe_n,
    output reg                   io_line_second_out,
    output reg                   io_line_second_oe_n,
    // sample timing towards the sensor pipeline
    output reg                   sample_strobe,
    // error conditions and write completion from the device
    input  wire                  supply_high,
    input  wire                  supply_low,
    input  wire                  alarm1_active,
    input  wire                  alarm2_active,
    input  wire                  over_range,
    input  wire                  nv_update_fail,
    input  wire                  nv_write_done,
    // self-test and checksum results
    input  wire                  selftest_fail_gyro,
    input  wire                  selftest_fail_x,
    input  wire                  selftest_fail_y,
    input  wire                  selftest_fail_z,
    input  wire                  selftest_diag_err,
    input  wire                  checksum_fail,
    // sensor controls
    output wire                  selftest_run,
    output wire                  checksum_run,
    output wire                  stim_negative,
    output wire                  stim_positive,
    output wire                  accel_bias_comp_en,
    output wire                  pop_align_en,
    output reg  [`SDC_DAC_W-1:0] aux_dac_code
);
    localparam [31:0] DR_CYC = (`SDC_DR_MIN_US + `SDC_DR_MAX_US) / 2 * `SDC_CLK_MHZ;
    localparam [11:0] DR_LOAD       = DR_CYC[11:0];
    localparam [31:0] TB_SHORT_LIM  = TB_SHORT_CYC - 1;
    localparam [31:0] TB_LONG_LIM   = TB_LONG_CYC - 1;

    // registers
    reg [15:0]            misc_control;
    reg [7:0]             sample_period_setting;
    reg [`SDC_DAC_W-1:0]  aux_converter_value;
    reg [15:0]            nv_write_counter;
    reg [15:0]            diagnostic_flags;
    reg [15:0]            next_misc;
    reg [15:0]            next_diag;

    // pin synchronisers: stage 0 feeds only stage 1
    reg [2:0]             cs_s;
    reg [2:0]             sclk_s;
    reg [2:0]             ext_s;
    reg [1:0]             mosi_s;

    always @(posedge clk) begin
        if (sys_rst) begin
            cs_s   <= 3'h7;
            sclk_s <= 3'h7;
            ext_s  <= 3'h0;
            mosi_s <= 2'h0;
        end else begin
            cs_s   <= {cs_s[1:0], spi_cs_n};
            sclk_s <= {sclk_s[1:0], spi_sclk};
            ext_s  <= {ext_s[1:0], ext_sample_clk};
            mosi_s <= {mosi_s[0], spi_mosi};
        end
    end

    wire cs_active = !cs_s[1];
    wire cs_end    = cs_s[1] && !cs_s[2];
    wire sclk_rise = sclk_s[1] && !sclk_s[2];
    wire sclk_fall = !sclk_s[1] && sclk_s[2];
    wire ext_rise  = ext_s[1] && !ext_s[2];

    // serial frame receive
    reg [3:0]  bit_cnt;
    reg [14:0] rx;
    reg [15:0] tx;
    reg [15:0] rd_word;
    reg [15:0] rd_mux;

    wire        word_done = cs_active && sclk_rise && (bit_cnt == `SDC_FRM_LAST_BIT);
    wire [15:0] rx_word   = {rx, mosi_s[1]};
    wire [6:0]  wa        = rx_word[`SDC_FRM_ADDR_HI:`SDC_FRM_ADDR_LO];
    wire [7:0]  wd        = rx_word[7:0];
    wire [6:0]  ra        = {wa[6:1], 1'b0};
    wire        wr        = word_done && rx_word[`SDC_FRM_WR];
    wire        rd        = word_done && !rx_word[`SDC_FRM_WR];
    wire        spi_err   = cs_end && (bit_cnt != 4'h0);

    always @(posedge clk) begin
        if (sys_rst) begin
            bit_cnt <= 4'h0;
            rx      <= 15'h0000;
        end else if (!cs_active) begin
            bit_cnt <= 4'h0;
        end else if (sclk_rise) begin
            rx      <= rx_word[14:0];
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always @* begin
        case (ra)
            `SDC_ADDR_NVCNT:   rd_mux = nv_write_counter;
            `SDC_ADDR_AUX_LO:  rd_mux = {{(16-`SDC_DAC_W){1'b0}}, aux_converter_value};
            `SDC_ADDR_MISC_LO: rd_mux = misc_control;
            `SDC_ADDR_SMPL:    rd_mux = {8'h00, sample_period_setting};
            `SDC_ADDR_DIAG:    rd_mux = diagnostic_flags;
            default:           rd_mux = 16'h0000;
        endcase
    end

    // answer to a read goes out in the following word, mode 3 timing
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_word  <= 16'h0000;
            tx       <= 16'h0000;
            spi_miso <= 1'b0;
        end else begin
            if (rd)
                rd_word <= rd_mux;
            if (cs_active && sclk_fall) begin
                if (bit_cnt == 4'h0) begin
                    spi_miso <= rd_word[15];
                    tx       <= {rd_word[14:0], 1'b0};
                end else begin
                    spi_miso <= tx[15];
                    tx       <= {tx[14:0], 1'b0};
                end
            end
        end
    end

    assign spi_miso_oe_n = cs_s[1];

    // sample timing
    reg  [31:0] base_cnt;
    reg  [6:0]  inc_cnt;
    wire        ext_mode = (sample_period_setting == `SDC_SP_EXT);
    wire [31:0] base_lim = sample_period_setting[`SDC_SP_TB] ? TB_LONG_LIM : TB_SHORT_LIM;
    wire        inc_wrap = (inc_cnt >= sample_period_setting[6:0]);
    wire        int_tick = (base_cnt == base_lim) && inc_wrap;
    wire        sample_tick = ext_mode ? ext_rise : int_tick;

    always @(posedge clk) begin
        if (sys_rst || ext_mode) begin
            base_cnt <= 32'h00000000;
            inc_cnt  <= 7'h00;
        end else if (base_cnt >= base_lim) begin
            base_cnt <= 32'h00000000;
            inc_cnt  <= inc_wrap ? 7'h00 : inc_cnt + 7'h01;
        end else begin
            base_cnt <= base_cnt + 32'h00000001;
        end
    end

    always @(posedge clk) begin
        if (sys_rst)
            sample_strobe <= 1'b0;
        else
            sample_strobe <= sample_tick;
    end

    // data-ready pulse: fixed midway between the least and longest width
    reg  [11:0] dr_cnt;
    wire        dr_pulse = (dr_cnt != 12'h000);
    wire        dr_level = misc_control[`SDC_MC_DR_POL] ? dr_pulse : !dr_pulse;
    wire        dr_first  = misc_control[`SDC_MC_DR_EN] && !misc_control[`SDC_MC_DR_SEL];
    wire        dr_second = misc_control[`SDC_MC_DR_EN] && misc_control[`SDC_MC_DR_SEL];

    always @(posedge clk) begin
        if (sys_rst)
            dr_cnt <= 12'h000;
        else if (sample_tick)
            dr_cnt <= DR_LOAD;
        else if (dr_pulse)
            dr_cnt <= dr_cnt - 12'h001;
    end

    // lines not routed to data-ready are released
    always @(posedge clk) begin
        if (sys_rst) begin
            io_line_first_out   <= 1'b0;
            io_line_first_oe_n  <= 1'b0;
            io_line_second_out  <= 1'b0;
            io_line_second_oe_n <= 1'b1;
        end else begin
            io_line_first_out   <= dr_first && dr_level;
            io_line_first_oe_n  <= !dr_first;
            io_line_second_out  <= dr_second && dr_level;
            io_line_second_oe_n <= !dr_second;
        end
    end

    // self-test and checksum jobs
    wire st_busy;
    wire st_done;
    wire ck_busy;
    wire ck_done;
    wire wr_misc_hi = wr && (wa == `SDC_ADDR_MISC_HI);
    wire st_start = wr_misc_hi && wd[`SDC_MC_SELFTEST-`SDC_MC_HI_BASE] && (!st_busy || st_done);
    wire ck_start = wr_misc_hi && wd[`SDC_MC_CHKSUM-`SDC_MC_HI_BASE] && (!ck_busy || ck_done);

    sdc_job_timer #(.CYCLES(SELFTEST_CYC)) u_selftest (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (st_start),
        .busy    (st_busy),
        .done    (st_done)
    );

    sdc_job_timer #(.CYCLES(CHKSUM_CYC)) u_checksum (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (ck_start),
        .busy    (ck_busy),
        .done    (ck_done)
    );

    assign selftest_run       = st_busy;
    assign checksum_run       = ck_busy;
    assign stim_negative      = misc_control[`SDC_MC_STNEG];
    assign stim_positive      = misc_control[`SDC_MC_STPOS];
    assign accel_bias_comp_en = misc_control[`SDC_MC_LABC];
    assign pop_align_en       = misc_control[`SDC_MC_POP];

    // misc_control: start bits set by host, cleared by hardware; a set wins
    always @* begin
        next_misc = misc_control;
        if (st_done)
            next_misc[`SDC_MC_SELFTEST] = 1'b0;
        if (ck_done)
            next_misc[`SDC_MC_CHKSUM] = 1'b0;
        if (wr && (wa == `SDC_ADDR_MISC_LO))
            next_misc[7:0] = wd & `SDC_MC_WMASK_LO;
        if (wr_misc_hi) begin
            next_misc[`SDC_MC_STNEG] = wd[`SDC_MC_STNEG-`SDC_MC_HI_BASE];
            next_misc[`SDC_MC_STPOS] = wd[`SDC_MC_STPOS-`SDC_MC_HI_BASE];
        end
        if (st_start)
            next_misc[`SDC_MC_SELFTEST] = 1'b1;
        if (ck_start)
            next_misc[`SDC_MC_CHKSUM] = 1'b1;
    end

    // diagnostic flags: read clears, events set in the same cycle win
    always @* begin
        next_diag = diagnostic_flags;
        if (rd && (ra == `SDC_ADDR_DIAG))
            next_diag = diagnostic_flags & `SDC_DG_KEEP;
        if (sample_tick) begin
            next_diag[`SDC_DG_SUP_HI] = supply_high;
            next_diag[`SDC_DG_SUP_LO] = supply_low;
            next_diag[`SDC_DG_AL1]    = next_diag[`SDC_DG_AL1] | alarm1_active;
            next_diag[`SDC_DG_AL2]    = next_diag[`SDC_DG_AL2] | alarm2_active;
            next_diag[`SDC_DG_OVR]    = next_diag[`SDC_DG_OVR] | over_range;
            next_diag[`SDC_DG_NVUPD]  = next_diag[`SDC_DG_NVUPD] | nv_update_fail;
        end
        if (spi_err)
            next_diag[`SDC_DG_SPI] = 1'b1;
        if (st_done) begin
            next_diag[`SDC_DG_ZA]     = next_diag[`SDC_DG_ZA] | selftest_fail_z;
            next_diag[`SDC_DG_YA]     = next_diag[`SDC_DG_YA] | selftest_fail_y;
            next_diag[`SDC_DG_XA]     = next_diag[`SDC_DG_XA] | selftest_fail_x;
            next_diag[`SDC_DG_GYRO]   = next_diag[`SDC_DG_GYRO] | selftest_fail_gyro;
            next_diag[`SDC_DG_STDIAG] = next_diag[`SDC_DG_STDIAG] | selftest_diag_err;
        end
        if (ck_done)
            next_diag[`SDC_DG_CHKSUM] = next_diag[`SDC_DG_CHKSUM] | checksum_fail;
    end

    // register writes
    always @(posedge clk) begin
        if (sys_rst) begin
            misc_control          <= `SDC_MC_RST;
            sample_period_setting <= `SDC_SP_RST;
            aux_converter_value   <= {`SDC_DAC_W{1'b0}};
            aux_dac_code          <= {`SDC_DAC_W{1'b0}};
            nv_write_counter      <= 16'h0000;
            diagnostic_flags      <= 16'h0000;
        end else begin
            misc_control     <= next_misc;
            diagnostic_flags <= next_diag;
            if (nv_write_done)
                nv_write_counter <= nv_write_counter + 16'h0001;
            if (wr && (wa == `SDC_ADDR_SMPL))
                sample_period_setting <= wd;
            if (wr && (wa == `SDC_ADDR_AUX_LO))
                aux_converter_value[7:0] <= wd;
            if (wr && (wa == `SDC_ADDR_AUX_HI))
                aux_converter_value[`SDC_DAC_W-1:8] <= wd[`SDC_DAC_HI_W-1:0];
            // latch strobe is acted on and never stored
            if (wr && (wa == `SDC_ADDR_GLOB) && wd[`SDC_GC_DAC_LATCH])
                aux_dac_code <= aux_converter_value;
        end
    end
endmodule // sdc_regs
`default_nettype wire

// ===== hdl/sdc_consts.vh
// constants for the sensor diagnostic and control register block
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH

// clock and timing
`define SDC_CLK_MHZ        25
`define SDC_TB_SHORT_NS    610350
`define SDC_TB_LONG_NS     18921000
`define SDC_DR_MIN_US      100
`define SDC_DR_MAX_US      200
`define SDC_SELFTEST_MS    35
`define SDC_CHKSUM_MS      20
`define SDC_NS_PER_US      1000
`define SDC_US_PER_MS      1000

// serial frame layout
`define SDC_FRM_WR         15
`define SDC_FRM_ADDR_HI    14
`define SDC_FRM_ADDR_LO    8
`define SDC_FRM_LAST_BIT   4'hF

// byte addresses on the serial port
`define SDC_ADDR_NVCNT     7'h00
`define SDC_ADDR_AUX_LO    7'h30
`define SDC_ADDR_AUX_HI    7'h31
`define SDC_ADDR_MISC_LO   7'h34
`define SDC_ADDR_MISC_HI   7'h35
`define SDC_ADDR_SMPL      7'h36
`define SDC_ADDR_DIAG      7'h3C
`define SDC_ADDR_GLOB      7'h3E

// misc_control fields
`define SDC_MC_DR_SEL      0
`define SDC_MC_DR_POL      1
`define SDC_MC_DR_EN       2
`define SDC_MC_POP         6
`define SDC_MC_LABC        7
`define SDC_MC_STPOS       8
`define SDC_MC_STNEG       9
`define SDC_MC_SELFTEST    10
`define SDC_MC_CHKSUM      11
`define SDC_MC_HI_BASE     8
`define SDC_MC_RST         16'h0006
`define SDC_MC_WMASK_LO    8'hC7

// sample_period_setting fields
`define SDC_SP_TB          7
`define SDC_SP_EXT         8'h00
`define SDC_SP_RST         8'h01

// global_command fields
`define SDC_GC_DAC_LATCH   2

// diagnostic_flags fields
`define SDC_DG_SUP_LO      0
`define SDC_DG_SUP_HI      1
`define SDC_DG_NVUPD       2
`define SDC_DG_SPI         3
`define SDC_DG_OVR         4
`define SDC_DG_STDIAG      5
`define SDC_DG_CHKSUM      6
`define SDC_DG_AL1         8
`define SDC_DG_AL2         9
`define SDC_DG_GYRO        10
`define SDC_DG_XA          13
`define SDC_DG_YA          14
`define SDC_DG_ZA          15
`define SDC_DG_KEEP        16'h0003

// auxiliary converter
`define SDC_DAC_W          12
`define SDC_DAC_HI_W       4

`endif

// ===== hdl/sdc_job_timer.v
// one-shot timer for the self-test and checksum jobs
`default_nettype none
module sdc_job_timer #(
    parameter integer CYCLES = 1
) (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // job control
    input  wire        start,
    output reg         busy,
    output wire        done
);
    localparam [31:0] LOAD = CYCLES;
    reg [31:0] cnt;

    assign done = busy && (cnt == 32'h00000001);

    always @(posedge clk) begin
        if (sys_rst) begin
            cnt  <= 32'h00000000;
            busy <= 1'b0;
        end else if (start) begin
            // a start on the finishing cycle restarts the job
            cnt  <= LOAD;
            busy <= 1'b1;
        end else if (busy) begin
            cnt  <= cnt - 32'h00000001;
            busy <= !done;
        end
    end
endmodule // sdc_job_timer
`default_nettype wire

// ===== dv/sdc_regs_properties.sv
// assertion checker for the sensor diagnostic and control register block
`include "sdc_consts.vh"
`default_nettype none
module sdc_regs_properties #(
    parameter integer SELFTEST_CYC = 30,
    parameter integer CHKSUM_CYC   = 20
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  sys_rst,
    // serial select
    input wire logic                  spi_cs_n,
    // data-ready lines and sample timing
    input wire logic                  io_line_first_out,
    input wire logic                  io_line_first_oe_n,
    input wire logic                  io_line_second_out,
    input wire logic                  io_line_second_oe_n,
    input wire logic                  sample_strobe,
    // sensor controls
    input wire logic                  selftest_run,
    input wire logic                  checksum_run,
    input wire logic                  stim_negative,
    input wire logic                  stim_positive,
    input wire logic                  accel_bias_comp_en,
    input wire logic                  pop_align_en,
    input wire logic [`SDC_DAC_W-1:0] aux_dac_code
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DR_MIN = `SDC_DR_MIN_US * `SDC_CLK_MHZ;
    localparam int DR_MAX = `SDC_DR_MAX_US * `SDC_CLK_MHZ;
    localparam int ST_LO  = SELFTEST_CYC - 1;
    localparam int ST_HI  = SELFTEST_CYC + 1;
    localparam int CK_HI  = CHKSUM_CYC + 2;
    logic [12:0] since;
    logic        dr_lvl;
    logic [15:0] st_len;
    wire         dr_on  = !io_line_first_oe_n || !io_line_second_oe_n;
    wire         dr_out = io_line_first_oe_n ? io_line_second_out : io_line_first_out;
    // level taken a cycle after the strobe, which the line lags
    always @(posedge clk) begin
        if (sys_rst) begin
            since  <= 13'h1FFF;
            dr_lvl <= 1'b0;
        end else if (sample_strobe) begin
            since <= 13'h0001;
        end else if (since != 13'h1FFF) begin
            since <= since + 13'h0001;
            if (since == 13'h0001)
                dr_lvl <= dr_out;
        end
    end
    always @(posedge clk)
        st_len <= (sys_rst || !selftest_run) ? 16'h0000 : st_len + 16'h0001;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_cs_idle;
        spi_cs_n [*8];
    endsequence
    sequence s_ck_start;
        $rose(checksum_run);
    endsequence
    a_strobe_single: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe too wide");
    a_one_line: assert property (io_line_first_oe_n || io_line_second_oe_n)
        else $error("both data-ready lines driven");
    a_idle_first_low: assert property (io_line_first_oe_n |-> !io_line_first_out)
        else $error("undriven first line not low");
    a_dr_min_width: assert property (since == DR_MIN && dr_on |-> dr_out == dr_lvl)
        else $error("data-ready pulse too short");
    a_dr_max_width: assert property (since == DR_MAX && dr_on |-> dr_out != dr_lvl)
        else $error("data-ready pulse too long");
    a_selftest_len: assert property ($fell(selftest_run) |-> st_len inside {[ST_LO:ST_HI]})
        else $error("self-test run length wrong");
    a_checksum_ends: assert property (s_ck_start |-> ##[1:CK_HI] !checksum_run)
        else $error("checksum run does not end");
    a_checksum_holds: assert property (s_ck_start |-> checksum_run [*8])
        else $error("checksum run ends early");
    a_dac_idle_hold: assert property (s_cs_idle |=> $stable(aux_dac_code))
        else $error("converter code changed while idle");
    a_ctrl_idle_hold: assert property (s_cs_idle |=>
        $stable({stim_negative, stim_positive, accel_bias_comp_en, pop_align_en}))
        else $error("controls changed while idle");
endmodule // sdc_regs_properties

bind sdc_regs sdc_regs_properties #(.SELFTEST_CYC(SELFTEST_CYC), .CHKSUM_CYC(CHKSUM_CYC)) u_props (
    .clk, .sys_rst, .spi_cs_n, .sample_strobe, .io_line_first_out, .io_line_first_oe_n,
    .io_line_second_out, .io_line_second_oe_n, .selftest_run, .checksum_run, .stim_negative,
    .stim_positive, .accel_bias_comp_en, .pop_align_en, .aux_dac_code
);
`default_nettype wire

// ===== dv/sdc_host_model.sv
// host side model that runs serial frames toward the register block
`default_nettype none
module sdc_host_model (
    // clock
    input  wire logic clk,
    // serial port pins
    output var  logic spi_cs_n,
    output var  logic spi_sclk,
    output var  logic spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b1;
        spi_mosi = 1'b0;
    end
    // sclk idles high; nbits under 16 tears the frame
    task frame(input logic [15:0] w, input int nbits, output logic [15:0] r);
        int i;
        r = 16'h0000;
        @(negedge clk);
        spi_cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (i = 0; i < nbits; i++) begin
            spi_sclk = 1'b0;
            spi_mosi = w[15 - i];
            repeat (4) @(negedge clk);
            spi_sclk = 1'b1;
            r = {r[14:0], spi_miso & !spi_miso_oe_n};
            repeat (4) @(negedge clk);
        end
        spi_cs_n = 1'b1;
        // released data line flips
        spi_mosi = ~spi_mosi;
        repeat (6) @(negedge clk);
    endtask
endmodule // sdc_host_model
`default_nettype wire

// ===== dv/sensor_diag_control_regs_tb_top.sv
// self-checking bench for the sensor diagnostic and control register block
`include "sdc_consts.vh"
`default_nettype none
module sensor_diag_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer ST_CYC = 30;
    localparam integer CK_CYC = 20;
    logic                  clk;
    logic                  sys_rst;
    logic                  ext_clk;
    logic                  nv_done;
    logic [11:0]           cond;
    logic [15:0]           rdata;
    wire                   cs_n, sclk, mosi, miso, miso_oe_n, strobe;
    wire                   l1_out, l1_oe_n, l2_out, l2_oe_n;
    wire                   st_run, ck_run, s_neg, s_pos, lab_en, pop_en;
    wire [`SDC_DAC_W-1:0]  dac;
    int                    n_errors;
    int                    num_checks;
    int                    cycles;
    int                    i;
    sdc_regs #(.TB_SHORT_CYC(20), .TB_LONG_CYC(50), .SELFTEST_CYC(ST_CYC), .CHKSUM_CYC(CK_CYC)) uut (
        .clk, .sys_rst, .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .ext_sample_clk(ext_clk),
        .io_line_first_out(l1_out), .io_line_first_oe_n(l1_oe_n),
        .io_line_second_out(l2_out), .io_line_second_oe_n(l2_oe_n), .sample_strobe(strobe),
        .supply_low(cond[0]), .supply_high(cond[1]), .nv_update_fail(cond[2]), .over_range(cond[3]),
        .alarm1_active(cond[4]), .alarm2_active(cond[5]), .nv_write_done(nv_done),
        .selftest_fail_gyro(cond[6]), .selftest_fail_x(cond[7]), .selftest_fail_y(cond[8]),
        .selftest_fail_z(cond[9]), .selftest_diag_err(cond[10]), .checksum_fail(cond[11]),
        .selftest_run(st_run), .checksum_run(ck_run), .stim_negative(s_neg), .stim_positive(s_pos),
        .accel_bias_comp_en(lab_en), .pop_align_en(pop_en), .aux_dac_code(dac)
    );
    sdc_host_model host (
        .clk, .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe_n(miso_oe_n)
    );
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        host.frame({1'b1, a, d}, 16, rdata);
    endtask
    // answer comes in the next frame
    task rd(input string name, input logic [6:0] a, input logic [15:0] exp);
        host.frame({1'b0, a, 8'h00}, 16, rdata);
        host.frame(16'h0000, 16, rdata);
        chk(name, rdata, exp);
    endtask
    task done_t(input string name);
        $display("test %s done", name);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            stop_test;
        end
    end
    initial begin
        sys_rst = 1'b1;
        ext_clk = 1'b0;
        nv_done = 1'b0;
        cond = 12'h000;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("first_oe_n", l1_oe_n, 16'h0000);
        chk("second_oe_n", l2_oe_n, 16'h0001);
        rd("misc", `SDC_ADDR_MISC_LO, 16'h0006);
        rd("aux", `SDC_ADDR_AUX_LO, 16'h0000);
        chk("first_out", l1_out, 16'h0001);
        done_t("reset");
        repeat (6) @(negedge clk) nv_done = !nv_done;
        wr(`SDC_ADDR_NVCNT, 8'h55);
        rd("nv_count", `SDC_ADDR_NVCNT, 16'h0003);
        done_t("counter");
        cond = 12'h03F;
        repeat (100) @(negedge clk);
        cond = 12'h00B;
        repeat (100) @(negedge clk);
        rd("diag_all", `SDC_ADDR_DIAG, 16'h0317);
        cond = 12'h000;
        repeat (100) @(negedge clk);
        rd("diag_keep", `SDC_ADDR_DIAG, 16'h0010);
        rd("diag_clear", `SDC_ADDR_DIAG, 16'h0000);
        host.frame(16'hFFFF, 12, rdata);
        rd("diag_torn", `SDC_ADDR_DIAG, 16'h0008);
        rd("diag_after", `SDC_ADDR_DIAG, 16'h0000);
        done_t("diagnostics");
        cond = 12'h800;
        wr(`SDC_ADDR_MISC_HI, 8'h08);
        chk("chk_run", ck_run, 16'h0001);
        repeat (CK_CYC) @(negedge clk);
        rd("misc_chk", `SDC_ADDR_MISC_LO, 16'h0006);
        rd("diag_chk", `SDC_ADDR_DIAG, 16'h0040);
        cond = 12'h6C0;
        wr(`SDC_ADDR_MISC_HI, 8'h04);
        chk("st_run", st_run, 16'h0001);
        repeat (ST_CYC) @(negedge clk);
        chk("st_end", st_run, 16'h0000);
        cond = 12'h000;
        rd("misc_st", `SDC_ADDR_MISC_LO, 16'h0006);
        rd("diag_st", `SDC_ADDR_DIAG, 16'hA420);
        done_t("jobs");
        wr(`SDC_ADDR_MISC_HI, 8'h03);
        wr(`SDC_ADDR_MISC_LO, 8'hC6);
        chk("controls", {12'h000, s_neg, s_pos, lab_en, pop_en}, 16'h000F);
        rd("misc_ctl", `SDC_ADDR_MISC_LO, 16'h03C6);
        repeat (50) @(negedge clk);
        wr(`SDC_ADDR_MISC_HI, 8'h00);
        chk("controls_off", {12'h000, s_neg, s_pos, lab_en, pop_en}, 16'h0003);
        done_t("controls");
        wr(`SDC_ADDR_AUX_LO, 8'hD9);
        wr(`SDC_ADDR_AUX_HI, 8'h04);
        chk("dac_staged", {4'h0, dac}, 16'h0000);
        wr(`SDC_ADDR_GLOB, 8'h04);
        chk("dac_latched", {4'h0, dac}, 16'h04D9);
        rd("aux_read", `SDC_ADDR_AUX_LO, 16'h04D9);
        rd("glob_read", `SDC_ADDR_GLOB, 16'h0000);
        done_t("converter");
        for (i = 0; i < 8; i++) begin
            wr(`SDC_ADDR_MISC_LO, i[7:0]);
            repeat (50) @(negedge clk);
            chk("first_oe_n", l1_oe_n, {15'h0000, !(i[2] && !i[0])});
            chk("second_oe_n", l2_oe_n, {15'h0000, !(i[2] && i[0])});
            chk("level", i[0] ? l2_out : l1_out, {15'h0000, i[2] && i[1]});
        end
        done_t("data_ready");
        wr(`SDC_ADDR_MISC_LO, 8'h06);
        wr(`SDC_ADDR_SMPL, 8'h00);
        repeat (4000) @(negedge clk);
        chk("ext_idle", l1_out, 16'h0000);
        ext_clk = 1'b1;
        repeat (4) @(negedge clk);
        ext_clk = 1'b0;
        repeat (2520) @(negedge clk);
        chk("pulse_min", l1_out, 16'h0001);
        repeat (1400) @(negedge clk);
        chk("pulse_max", l1_out, 16'h0000);
        repeat (1500) @(negedge clk);
        done_t("external_clock");
        stop_test;
    end
endmodule // sensor_diag_control_regs_tb_top
`default_nettype wire
